// >>> src/wdc_pkg.sv
package wdc_pkg;
    // register offsets (5-bit address space)
    localparam logic [4:0] WDC_ADDR_UNLOCK = 5'h02;
    localparam logic [4:0] WDC_ADDR_SETUP  = 5'h03;
    localparam logic [4:0] WDC_ADDR_KICK   = 5'h04;
    // reset values and key
    localparam logic [7:0] WDC_UNLOCK_RST  = 8'h00;
    localparam logic [7:0] WDC_SETUP_RST   = 8'h09;
    localparam logic [7:0] WDC_KICK_RST    = 8'h00;
    localparam logic [7:0] WDC_UNLOCK_KEY  = 8'h5A;
    // setup field positions
    localparam int WDC_DIS_LSB  = 6;
    localparam int WDC_TOUT_LSB = 3;
    localparam int WDC_WIN_LSB  = 0;
    localparam logic [1:0] WDC_DIS_CODE = 2'h1;
    localparam int WDC_KICK_BIT = 0;
    // timing: 100 MHz clock, one tick per millisecond
    localparam int WDC_CLK_MHZ  = 100;
    localparam int WDC_TICK_US  = 1000;
    localparam int WDC_TICK_CYC = WDC_CLK_MHZ * WDC_TICK_US;

    // one register access from the serial engines
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } wdc_req_t;

    // nominal period in ms from a 3-bit timeout code
    function automatic logic [11:0] wdc_tout_ms(input logic [2:0] c);
        case (c)
            3'h0:    wdc_tout_ms = 12'h050;
            3'h1:    wdc_tout_ms = 12'h0A0;
            3'h2:    wdc_tout_ms = 12'h140;
            3'h3:    wdc_tout_ms = 12'h1E0;
            3'h4:    wdc_tout_ms = 12'h320;
            3'h5:    wdc_tout_ms = 12'h3E8;
            3'h6:    wdc_tout_ms = 12'h7D0;
            default: wdc_tout_ms = 12'hFA0;
        endcase
    endfunction : wdc_tout_ms

    // nominal period in ms from a 3-bit window code
    function automatic logic [11:0] wdc_win_ms(input logic [2:0] c);
        case (c)
            3'h0:    wdc_win_ms = 12'h00A;
            3'h1:    wdc_win_ms = 12'h028;
            3'h2:    wdc_win_ms = 12'h050;
            3'h3:    wdc_win_ms = 12'h078;
            3'h4:    wdc_win_ms = 12'h0A0;
            3'h5:    wdc_win_ms = 12'h0F0;
            3'h6:    wdc_win_ms = 12'h140;
            default: wdc_win_ms = 12'h190;
        endcase
    endfunction : wdc_win_ms
endpackage : wdc_pkg

// >>> src/wdc_regs.sv
`timescale 1ns/1ns
// Operation
// - spi and i2c requests reach one shared register file; spi wins a same-cycle write.
// - setup register writes allowed only while unlock key holds 0x5A.
// - any other unlock value, reset included, blocks setup writes.
// - setup bits 5:3 select timeout period 80 to 4000 ms.
// - setup bits 2:0 select window period 10 to 400 ms.
// - periods are nominal; plus or minus 25 percent tolerated.
// - kick bit clears itself once the counter restarts.
module wdc_regs #(
    parameter int TICK_CYC = wdc_pkg::WDC_TICK_CYC
) (
    // clock, reset, enable
    input  wire logic              sys_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              clk_en_i,
    // power-on resets, active low, synchronous to sys_clk_i
    input  wire logic              battery_power_on_reset_b_i,
    input  wire logic              regulator_one_power_on_reset_b_i,
    // spi and i2c engine requests
    input  wire wdc_pkg::wdc_req_t spi_req_i,
    input  wire wdc_pkg::wdc_req_t i2c_req_i,
    // read data
    output logic [7:0]             spi_rdata_o,
    output logic [7:0]             i2c_rdata_o,
    // watchdog state
    output logic                   watchdog_unit_enabled_o,
    output logic [11:0]            tout_ms_o,
    output logic [11:0]            win_ms_o,
    output logic                   ms_tick_o,
    output logic                   kick_pending_o,
    input  wire logic              counter_restart_i
);
    import wdc_pkg::*;

    logic [7:0]  unlock_key;
    logic [7:0]  setup;
    logic [7:0]  kick;
    logic [31:0] tick_cnt;

    // spi wins if both engines write in the same cycle
    wdc_req_t req;
    assign req = spi_req_i.wr ? spi_req_i : i2c_req_i;

    // address decode
    wire sel_unlock = req.addr == WDC_ADDR_UNLOCK;
    wire sel_setup  = req.addr == WDC_ADDR_SETUP;
    wire sel_kick   = req.addr == WDC_ADDR_KICK;
    wire unlocked   = unlock_key == WDC_UNLOCK_KEY;
    wire wr_unlock  = clk_en_i && req.wr && sel_unlock;
    wire wr_setup   = clk_en_i && req.wr && sel_setup && unlocked;
    wire set_kick   = clk_en_i && req.wr && sel_kick && req.wdata[WDC_KICK_BIT];

    // read mux, kick is write-only
    function automatic logic [7:0] rd_mux(input logic [4:0] a, input logic [7:0] k,
                                          input logic [7:0] s);
        if (a == WDC_ADDR_UNLOCK) begin
            rd_mux = k;
        end else if (a == WDC_ADDR_SETUP) begin
            rd_mux = s;
        end else begin
            rd_mux = 8'h00;
        end
    endfunction : rd_mux

    wire [7:0] next_spi_rdata = rd_mux(spi_req_i.addr, unlock_key, setup);
    wire [7:0] next_i2c_rdata = rd_mux(i2c_req_i.addr, unlock_key, setup);

    // unlock key, reset by regulator one power-on
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            unlock_key <= WDC_UNLOCK_RST;
        end else if (!regulator_one_power_on_reset_b_i) begin
            unlock_key <= WDC_UNLOCK_RST;
        end else if (wr_unlock) begin
            unlock_key <= req.wdata;
        end
    end

    // setup, reset by battery power-on
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            setup <= WDC_SETUP_RST;
        end else if (!battery_power_on_reset_b_i) begin
            setup <= WDC_SETUP_RST;
        end else if (wr_setup) begin
            setup <= req.wdata;
        end
    end

    // kick self-clears on restart; a new kick in that cycle wins
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            kick <= WDC_KICK_RST;
        end else if (!regulator_one_power_on_reset_b_i) begin
            kick <= WDC_KICK_RST;
        end else if (set_kick) begin
            kick[WDC_KICK_BIT] <= 1'b1;
        end else if (clk_en_i && counter_restart_i) begin
            kick[WDC_KICK_BIT] <= 1'b0;
        end
    end

    // read data registers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spi_rdata_o <= 8'h00;
            i2c_rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            spi_rdata_o <= next_spi_rdata;
            i2c_rdata_o <= next_i2c_rdata;
        end
    end

    // millisecond time base for nominal periods
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt  <= 32'h0;
            ms_tick_o <= 1'b0;
        end else if (clk_en_i) begin
            ms_tick_o <= tick_cnt == 32'(TICK_CYC - 1);
            tick_cnt  <= (tick_cnt == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt + 32'h1;
        end
    end

    assign watchdog_unit_enabled_o = setup[WDC_DIS_LSB +: 2] != WDC_DIS_CODE;
    assign tout_ms_o      = wdc_tout_ms(setup[WDC_TOUT_LSB +: 3]);
    assign win_ms_o       = wdc_win_ms(setup[WDC_WIN_LSB +: 3]);
    assign kick_pending_o = kick[WDC_KICK_BIT];

    // assertions
    property p_locked_setup;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (unlock_key != WDC_UNLOCK_KEY && battery_power_on_reset_b_i) |=> $stable(setup);
    endproperty
    a_locked_setup: assert property (p_locked_setup) else $error("setup changed while locked");

    property p_unlocked_write;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (clk_en_i && spi_req_i.wr && spi_req_i.addr == WDC_ADDR_SETUP && unlocked
         && battery_power_on_reset_b_i) |=> setup == $past(spi_req_i.wdata);
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) else $error("keyed write lost");

    property p_disable;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        watchdog_unit_enabled_o == (setup[WDC_DIS_LSB +: 2] != 2'h1);
    endproperty
    a_disable: assert property (p_disable) else $error("enable decode wrong");

    property p_tout;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (setup[WDC_TOUT_LSB +: 3] == 3'h7) |-> tout_ms_o == 12'hFA0;
    endproperty
    a_tout: assert property (p_tout) else $error("timeout decode wrong");

    property p_tout_min;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (setup[WDC_TOUT_LSB +: 3] == 3'h0) |-> tout_ms_o == 12'h050;
    endproperty
    a_tout_min: assert property (p_tout_min) else $error("shortest timeout wrong");

    property p_win;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (setup[WDC_WIN_LSB +: 3] == 3'h0) |-> win_ms_o == 12'h00A;
    endproperty
    a_win: assert property (p_win) else $error("window decode wrong");

    property p_win_max;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (setup[WDC_WIN_LSB +: 3] == 3'h7) |-> win_ms_o == 12'h190;
    endproperty
    a_win_max: assert property (p_win_max) else $error("longest window wrong");

    property p_kick_clear;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (clk_en_i && counter_restart_i && !set_kick && regulator_one_power_on_reset_b_i)
        |=> !kick_pending_o;
    endproperty
    a_kick_clear: assert property (p_kick_clear) else $error("kick not cleared");

    property p_kick_set;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (set_kick && regulator_one_power_on_reset_b_i) |=> kick_pending_o;
    endproperty
    a_kick_set: assert property (p_kick_set) else $error("kick set lost");

    property p_same_read;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (clk_en_i && spi_req_i.addr == i2c_req_i.addr) |=> spi_rdata_o == i2c_rdata_o;
    endproperty
    a_same_read: assert property (p_same_read) else $error("ports disagree");

    property p_tick;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (ms_tick_o && clk_en_i) |=> !ms_tick_o;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too long");

    property p_tick_freeze;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !clk_en_i |=> $stable(tick_cnt) && $stable(ms_tick_o);
    endproperty
    a_tick_freeze: assert property (p_tick_freeze) else $error("time base moved");

    property p_unlock_key;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_unlock && regulator_one_power_on_reset_b_i) |=> unlock_key == $past(req.wdata);
    endproperty
    a_unlock_key: assert property (p_unlock_key) else $error("key write lost");

    property p_regulator_reset;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !regulator_one_power_on_reset_b_i |=> unlock_key == WDC_UNLOCK_RST && !kick_pending_o;
    endproperty
    a_regulator_reset: assert property (p_regulator_reset) else $error("key or kick kept");

    property p_battery_reset;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !battery_power_on_reset_b_i |=> setup == WDC_SETUP_RST && watchdog_unit_enabled_o;
    endproperty
    a_battery_reset: assert property (p_battery_reset) else $error("setup kept");

    c_unlock: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) wr_unlock ##[1:20] wr_setup);
    c_kick:   cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) set_kick ##1 counter_restart_i);
    c_off:    cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) !watchdog_unit_enabled_o);
    c_frozen: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) !clk_en_i && req.wr);
endmodule : wdc_regs

// >>> sim/wdc_host_model.sv
`timescale 1ns/1ns
module wdc_host_model (
    // clock and read data
    input  wire logic         sys_clk_i,
    input  wire logic [7:0]   spi_rdata_i,
    input  wire logic [7:0]   i2c_rdata_i,
    // requests to the engines
    output wdc_pkg::wdc_req_t spi_req_o,
    output wdc_pkg::wdc_req_t i2c_req_o
);
    import wdc_pkg::*;
    // both engines idle
    initial begin
        spi_req_o = '0;
        i2c_req_o = '0;
    end
    task automatic wr(input logic p, input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        if (p)
            i2c_req_o <= '{1'h1, 1'h0, a, d};
        else
            spi_req_o <= '{1'h1, 1'h0, a, d};
        @(posedge sys_clk_i);
        if (p)
            i2c_req_o <= '{1'h0, 1'h0, a, ~d};
        else
            spi_req_o <= '{1'h0, 1'h0, a, ~d};
    endtask : wr
    // address held, data taken after two edges
    task automatic rd(input logic p, input logic [4:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        if (p)
            i2c_req_o.addr <= a;
        else
            spi_req_o.addr <= a;
        repeat (2) @(posedge sys_clk_i);
        #1 d = p ? i2c_rdata_i : spi_rdata_i;
    endtask : rd
endmodule : wdc_host_model

// >>> sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import wdc_pkg::*;
    logic        sys_clk_i, rst_b_i, clk_en_i, bat_b, reg_b, restart, unit_en, tick, kick;
    wdc_req_t    spi_req, i2c_req;
    logic [7:0]  spi_rd, i2c_rd, rv, sv;
    logic [11:0] tout, win, et, ew;
    logic        ee;
    int          n_mismatch, samples_checked, n_tick;
    // rows: setup byte, timeout ms, window ms, enabled
    logic [32:0] rows [8] = '{{8'h07, 12'h050, 12'h190, 1'h1},
                              {8'h4E, 12'h0A0, 12'h140, 1'h0},
                              {8'h95, 12'h140, 12'h0F0, 1'h1},
                              {8'hDC, 12'h1E0, 12'h0A0, 1'h1},
                              {8'h23, 12'h320, 12'h078, 1'h1},
                              {8'h6A, 12'h3E8, 12'h050, 1'h0},
                              {8'hB1, 12'h7D0, 12'h028, 1'h1},
                              {8'hF8, 12'hFA0, 12'h00A, 1'h1}};
    // device and host
    wdc_regs #(.TICK_CYC(10)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
        .battery_power_on_reset_b_i(bat_b), .regulator_one_power_on_reset_b_i(reg_b),
        .spi_req_i(spi_req), .i2c_req_i(i2c_req), .spi_rdata_o(spi_rd),
        .i2c_rdata_o(i2c_rd), .watchdog_unit_enabled_o(unit_en), .tout_ms_o(tout),
        .win_ms_o(win),
        .ms_tick_o(tick), .kick_pending_o(kick), .counter_restart_i(restart));
    wdc_host_model u_host (
        .sys_clk_i(sys_clk_i), .spi_rdata_i(spi_rd), .i2c_rdata_i(i2c_rd),
        .spi_req_o(spi_req), .i2c_req_o(i2c_req));
    // compare and count
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // read one register and compare
    task automatic rck(input logic p, input logic [4:0] a, input logic [7:0] e);
        u_host.rd(p, a, rv);
        chk({4'h0, rv}, {4'h0, e});
    endtask : rck
    // verdict
    task automatic end_sim();
        $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    // clock
    initial begin
        sys_clk_i = 1'h0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // watchdog
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
    // main sequence
    initial begin
        {rst_b_i, restart} = 2'h0;
        {clk_en_i, bat_b, reg_b} = 3'h7;
        repeat (6) @(posedge sys_clk_i);
        chk(tout, 12'h0A0);
        chk(win, 12'h028);
        rst_b_i <= 1'h1;
        rck(1'h0, WDC_ADDR_UNLOCK, 8'h00);
        rck(1'h1, WDC_ADDR_SETUP, 8'h09);
        u_host.wr(1'h0, WDC_ADDR_SETUP, 8'h41);
        rck(1'h0, WDC_ADDR_SETUP, 8'h09);
        u_host.wr(1'h1, WDC_ADDR_UNLOCK, WDC_UNLOCK_KEY);
        // rows, written on one engine, read on the other
        for (int k = 0; k < 8; k++) begin
            {sv, et, ew, ee} = rows[k];
            u_host.wr(k[0], WDC_ADDR_SETUP, sv);
            rck(~k[0], WDC_ADDR_SETUP, sv);
            chk(tout, et);
            chk(win, ew);
            chk({11'h0, unit_en}, {11'h0, ee});
        end
        u_host.wr(1'h0, WDC_ADDR_UNLOCK, 8'h5B);
        u_host.wr(1'h0, WDC_ADDR_SETUP, 8'h00);
        rck(1'h0, WDC_ADDR_SETUP, 8'hF8);
        // key write while clock enable is low is dropped
        @(posedge sys_clk_i);
        clk_en_i <= 1'h0;
        u_host.wr(1'h0, WDC_ADDR_UNLOCK, WDC_UNLOCK_KEY);
        clk_en_i <= 1'h1;
        rck(1'h0, WDC_ADDR_UNLOCK, 8'h5B);
        // one tick per ten cycles over thirty cycles
        n_tick = 0;
        repeat (30) begin
            @(posedge sys_clk_i);
            #1 n_tick += int'(tick);
        end
        chk(12'(n_tick), 12'h003);
        // kick stands, reads zero, clears on restart
        u_host.wr(1'h1, WDC_ADDR_KICK, 8'h01);
        rck(1'h1, WDC_ADDR_KICK, 8'h00);
        chk({11'h0, kick}, 12'h001);
        @(posedge sys_clk_i);
        restart <= 1'h1;
        @(posedge sys_clk_i);
        restart <= 1'h0;
        @(posedge sys_clk_i);
        #1 chk({11'h0, kick}, 12'h000);
        rck(1'h0, 5'h1F, 8'h00);
        // power-on resets bring back reset values
        @(posedge sys_clk_i);
        {bat_b, reg_b} <= 2'h0;
        @(posedge sys_clk_i);
        {bat_b, reg_b} <= 2'h3;
        rck(1'h0, WDC_ADDR_UNLOCK, 8'h00);
        rck(1'h1, WDC_ADDR_SETUP, 8'h09);
        end_sim();
    end
endmodule : tb_top
